// ---- design/csd_core.sv ----
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
module csd_core
    import csd_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // instruction stream from fetch
    input wire logic I_INSTR_VALID,
    input wire logic [15:0] I_INSTR,
    input wire logic I_NEXT_TWO_WORD,
    // data memory
    output logic [11:0] O_DMEM_ADDR,
    output logic O_DMEM_RD,
    input wire logic [7:0] I_DMEM_DATA,
    // core state
    output logic [3:0] O_PHASE,
    output logic O_SKIP,
    output logic O_NOP_CYCLE,
    output logic [7:0] O_W,
    output logic O_CARRY
);
    csd_phase_t phase_q;
    csd_phase_t phase_d;
    logic run_q;
    logic [7:0] w_q;
    logic c_q;
    logic dc_q;
    logic [3:0] bsr_q;
    logic lt_q;
    logic gt_q;
    logic daw_q;
    logic nop_q;
    logic [1:0] skip_left_q;
    logic [1:0] skip_left_d;
    logic [7:0] mem_q;
    logic [7:0] skips_q;
    logic skip_q;
    logic [11:0] dmem_addr_q;
    logic dmem_rd_q;
    logic [31:0] hrdata_q;
    logic wr_pend_q;
    logic [7:0] wr_ofs_q;
    csd_daw_t daw_res;
    csd_cmp_t cmp_res;
    logic [11:0] f_addr;

    // phase and slot decode
    wire ph_dec = run_q && (phase_q == DECODE_PHASE);
    wire ph_read = run_q && (phase_q == READ_PHASE);
    wire ph_proc = run_q && (phase_q == PROCESS_PHASE);
    wire ph_wb = run_q && (phase_q == WRITEBACK_PHASE);
    wire slot_free = (skip_left_q == SKIP_NONE);
    wire take = ph_dec && slot_free && I_INSTR_VALID;
    wire dec_lt = (I_INSTR[15:9] == CPLT_OPC);
    wire dec_gt = (I_INSTR[15:9] == CPGT_OPC);
    wire dec_daw = (I_INSTR == DAW_WORD);
    wire skip_hit = (lt_q && cmp_res.lt) || (gt_q && cmp_res.gt);
    wire daw_wr = ph_wb && daw_q;

    // bus decode
    wire ahb_go = I_HSEL && I_HTRANS[HTRANS_ACTIVE_BIT] && I_HREADY;
    wire [7:0] rofs = I_HADDR[7:0];
    wire wr_w = wr_pend_q && (wr_ofs_q == OFS_WORKING_REGISTER_FILE);
    wire wr_st = wr_pend_q && (wr_ofs_q == OFS_STATUS);
    wire wr_bsr = wr_pend_q && (wr_ofs_q == OFS_BSR);
    wire wr_ctl = wr_pend_q && (wr_ofs_q == OFS_CTRL);
    wire [31:0] rd_word =
        (rofs == OFS_WORKING_REGISTER_FILE) ? {24'h000000, w_q} :
        (rofs == OFS_STATUS) ? {30'h00000000, dc_q, c_q} :
        (rofs == OFS_BSR) ? {28'h0000000, bsr_q} :
        (rofs == OFS_CTRL) ? {31'h00000000, run_q} :
        (rofs == OFS_SKIPS) ? {24'h000000, skips_q} :
        (rofs == OFS_STATE) ? {24'h000000, 1'b0, nop_q, skip_left_q, phase_q} :
        32'h00000000;

    csd_fsel u_fsel (
        .i_faddr(I_INSTR[7:0]),
        .i_access(I_INSTR[ACC_BIT]),
        .i_bsr(bsr_q),
        .i_mem(mem_q),
        .i_w(w_q),
        .o_addr(f_addr),
        .o_cmp(cmp_res)
    );

    csd_daw u_daw (
        .i_w(w_q),
        .i_c(c_q),
        .i_dc(dc_q),
        .o_res(daw_res)
    );

    always_comb begin
        phase_d = phase_q;
        if (run_q) begin
            unique case (phase_q)
                DECODE_PHASE: phase_d = READ_PHASE;
                READ_PHASE: phase_d = PROCESS_PHASE;
                PROCESS_PHASE: phase_d = WRITEBACK_PHASE;
                WRITEBACK_PHASE: phase_d = DECODE_PHASE;
            endcase
        end
    end

    // a taken skip arms one idle cycle, or two over a two-word instruction
    assign skip_left_d = (ph_proc && skip_hit) ? (I_NEXT_TWO_WORD ? SKIP_TWO : SKIP_ONE) :
        (ph_dec && !slot_free) ? skip_left_q - SKIP_ONE : skip_left_q;

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            phase_q <= DECODE_PHASE;
            skip_left_q <= SKIP_NONE;
        end else begin
            phase_q <= phase_d;
            skip_left_q <= skip_left_d;
        end
    end

    // the fetched word is dropped while a skip is pending
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            lt_q <= 1'b0;
            gt_q <= 1'b0;
            daw_q <= 1'b0;
            nop_q <= 1'b0;
        end else if (ph_dec) begin
            lt_q <= take && dec_lt;
            gt_q <= take && dec_gt;
            daw_q <= take && dec_daw;
            nop_q <= !slot_free;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            dmem_addr_q <= 12'h000;
            dmem_rd_q <= 1'b0;
        end else if (ph_dec) begin
            dmem_addr_q <= f_addr;
            dmem_rd_q <= take && (dec_lt || dec_gt);
        end else if (ph_read) begin
            dmem_rd_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            mem_q <= 8'h00;
        end else if (ph_read && dmem_rd_q) begin
            mem_q <= I_DMEM_DATA;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            skip_q <= 1'b0;
            skips_q <= 8'h00;
        end else begin
            skip_q <= ph_proc && skip_hit;
            skips_q <= skips_q + {7'h00, ph_proc && skip_hit};
        end
    end

    // core writeback wins over a bus write landing in the same cycle
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            w_q <= WORKING_REGISTER_FILE_RST;
            c_q <= 1'b0;
        end else if (daw_wr) begin
            w_q <= daw_res.w;
            c_q <= daw_res.c;
        end else begin
            w_q <= wr_w ? I_HWDATA[7:0] : w_q;
            c_q <= wr_st ? I_HWDATA[STATUS_C_BIT] : c_q;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            dc_q <= 1'b0;
            bsr_q <= BSR_RST;
            run_q <= RUN_RST;
        end else begin
            dc_q <= wr_st ? I_HWDATA[STATUS_DC_BIT] : dc_q;
            bsr_q <= wr_bsr ? I_HWDATA[3:0] : bsr_q;
            run_q <= wr_ctl ? I_HWDATA[CTRL_RUN_BIT] : run_q;
        end
    end

    // zero wait states: read data is prepared in the address phase
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            hrdata_q <= 32'h00000000;
            wr_pend_q <= 1'b0;
            wr_ofs_q <= 8'h00;
        end else begin
            if (ahb_go && !I_HWRITE) begin
                hrdata_q <= rd_word;
            end
            wr_pend_q <= ahb_go && I_HWRITE;
            wr_ofs_q <= ahb_go ? rofs : wr_ofs_q;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_HREADYOUT <= 1'b0;
            O_HRESP <= HRESP_OKAY;
        end else begin
            O_HREADYOUT <= 1'b1;
            O_HRESP <= HRESP_OKAY;
        end
    end

    assign O_HRDATA = hrdata_q;
    assign O_DMEM_ADDR = dmem_addr_q;
    assign O_DMEM_RD = dmem_rd_q;
    assign O_PHASE = phase_q;
    assign O_SKIP = skip_q;
    assign O_NOP_CYCLE = nop_q;
    assign O_W = w_q;
    assign O_CARRY = c_q;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);

    // a bus write may stop the ring mid-cycle, so each step is checked on its own
    phase_ring_a: assert property (
        run_q |=> phase_q == {$past(phase_q[2:0]), $past(phase_q[3])}
    ) else $error("phase sequence broken");

    ring_frozen_a: assert property (
        !run_q |=> $stable(phase_q)
    ) else $error("phase moved while stopped");

    skip_less_a: assert property (
        ph_proc && lt_q && (mem_q < w_q) |=> skip_left_q != SKIP_NONE && skip_q
    ) else $error("less-than compare did not skip");

    no_skip_a: assert property (
        ph_proc && lt_q && (mem_q >= w_q) && slot_free |=> slot_free && !skip_q
    ) else $error("skip taken without cause");

    flags_kept_a: assert property (
        ph_wb && (lt_q || gt_q) && !wr_pend_q |=> w_q == $past(w_q) && c_q == $past(c_q)
    ) else $error("compare altered working register or carry");

    two_word_a: assert property (
        ph_proc && skip_hit && I_NEXT_TWO_WORD
            |=> skip_left_q == SKIP_TWO ##4 nop_q ##4 nop_q ##4 !nop_q
    ) else $error("two-word skip not two idle cycles");

    idle_slot_a: assert property (
        ph_dec && !slot_free |=> nop_q && !lt_q && !gt_q && !daw_q
    ) else $error("discarded slot executed an instruction");

    idle_quiet_a: assert property (
        nop_q |-> !dmem_rd_q && !daw_wr
    ) else $error("idle cycle performed an operation");

    bank_sel_a: assert property (
        ph_dec && I_INSTR[ACC_BIT] |=> dmem_addr_q == {$past(bsr_q), $past(I_INSTR[7:0])}
    ) else $error("banked address wrong");

    access_bank_a: assert property (
        ph_dec && !I_INSTR[ACC_BIT] && (I_INSTR[7:0] < ACCESS_SPLIT)
            |=> dmem_addr_q[11:8] == ACCESS_LOW_BANK
    ) else $error("access bank address wrong");

    low_nibble_a: assert property (
        daw_wr && (w_q[3:0] > BCD_MAX) |=> w_q[3:0] == $past(w_q[3:0]) + BCD_ADJ
    ) else $error("low nibble not corrected");

    carry_set_a: assert property (
        daw_wr && c_q |=> c_q
    ) else $error("decimal adjust cleared carry");

    daw_decode_a: assert property (
        take && (I_INSTR == DAW_WORD) |=> ##2 daw_wr ##1 !daw_wr
    ) else $error("decimal adjust not written in writeback");

    skip_one_c: cover property (ph_proc && skip_hit && !I_NEXT_TWO_WORD);
    skip_two_c: cover property (ph_proc && skip_hit && I_NEXT_TWO_WORD);
    daw_carry_c: cover property (daw_wr && daw_res.c && !c_q);
    bus_write_c: cover property (wr_w ##1 ph_dec);
endmodule

// ---- design/csd_pkg.sv ----
package csd_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_WORKING_REGISTER_FILE = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BSR = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_SKIPS = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;
    // field positions
    localparam int STATUS_C_BIT = 0;
    localparam int STATUS_DC_BIT = 1;
    localparam int CTRL_RUN_BIT = 0;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam int ACC_BIT = 8;
    // reset values
    localparam logic [7:0] WORKING_REGISTER_FILE_RST = 8'h00;
    localparam logic [3:0] BSR_RST = 4'h0;
    localparam logic RUN_RST = 1'b1;
    localparam logic HRESP_OKAY = 1'b0;
    // instruction encodings
    localparam logic [6:0] CPLT_OPC = 7'h30;
    localparam logic [6:0] CPGT_OPC = 7'h32;
    localparam logic [15:0] DAW_WORD = 16'h0007;
    // access bank split
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    // decimal correction
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_ADJ = 4'h6;
    // idle cycles after a taken skip
    localparam logic [1:0] SKIP_NONE = 2'h0;
    localparam logic [1:0] SKIP_ONE = 2'h1;
    localparam logic [1:0] SKIP_TWO = 2'h2;

    typedef enum logic [3:0] {
        DECODE_PHASE = 4'h1,
        READ_PHASE = 4'h2,
        PROCESS_PHASE = 4'h4,
        WRITEBACK_PHASE = 4'h8
    } csd_phase_t;

    typedef struct packed {
        logic [7:0] w;
        logic c;
    } csd_daw_t;

    typedef struct packed {
        logic lt;
        logic gt;
    } csd_cmp_t;
endpackage

// ---- design/csd_daw.sv ----
module csd_daw
    import csd_pkg::*;
(
    // working register and flags
    input wire logic [7:0] i_w,
    input wire logic i_c,
    input wire logic i_dc,
    // corrected value and carry
    output csd_daw_t o_res
);
    logic lo_fix;
    logic hi_fix;
    logic [3:0] lo_res;
    logic [4:0] hi_sum;
    logic [4:0] hi_res;

    assign lo_fix = (i_w[3:0] > BCD_MAX) || i_dc;
    assign lo_res = lo_fix ? i_w[3:0] + BCD_ADJ : i_w[3:0];
    assign hi_sum = {1'b0, i_w[7:4]} + {4'h0, i_dc};
    assign hi_fix = (hi_sum > {1'b0, BCD_MAX}) || i_c;
    assign hi_res = hi_fix ? hi_sum + {1'b0, BCD_ADJ} : hi_sum;
    // carry only ever sets, so a chained BCD add keeps its overflow
    assign o_res.w = {hi_res[3:0], lo_res};
    assign o_res.c = i_c | hi_res[4];
endmodule

// ---- design/csd_fsel.sv ----
module csd_fsel
    import csd_pkg::*;
(
    // operand address
    input wire logic [7:0] i_faddr,
    input wire logic i_access,
    input wire logic [3:0] i_bsr,
    // compare operands
    input wire logic [7:0] i_mem,
    input wire logic [7:0] i_w,
    // results
    output logic [11:0] o_addr,
    output csd_cmp_t o_cmp
);
    logic [3:0] acc_bank;
    logic [8:0] diff;

    assign acc_bank = (i_faddr < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
    assign o_addr = i_access ? {i_bsr, i_faddr} : {acc_bank, i_faddr};
    // borrow out of a 9-bit subtract gives the unsigned order
    assign diff = {1'b0, i_mem} - {1'b0, i_w};
    assign o_cmp.lt = diff[8];
    assign o_cmp.gt = !diff[8] && (diff[7:0] != 8'h00);
endmodule

// ---- bench/compare_skip_and_decimal_adjust_bench.sv ----
module compare_skip_and_decimal_adjust_bench
    import csd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [15:0] i;
        logic [7:0] w;
        logic [1:0] f;
        logic [3:0] b;
        logic [7:0] m;
        logic t;
        logic [11:0] a;
        logic s;
        logic [1:0] n;
        logic [7:0] ew;
        logic ec;
    } csd_row_t;

    // word, w, {dc,c}, bank, byte, two-word, address, skip, idle cycles, w after, c after
    localparam csd_row_t ROWS [14] = '{
        {16'h6020, 8'h20, 2'h0, 4'h5, 8'h10, 1'h0, 12'h020, 1'h1, 2'h1, 8'h20, 1'h0},
        {16'h6080, 8'h20, 2'h0, 4'h5, 8'h20, 1'h0, 12'hF80, 1'h0, 2'h0, 8'h20, 1'h0},
        {16'h6160, 8'h01, 2'h1, 4'h5, 8'hFF, 1'h0, 12'h560, 1'h0, 2'h0, 8'h01, 1'h1},
        {16'h615F, 8'h80, 2'h2, 4'hA, 8'h7F, 1'h1, 12'hA5F, 1'h1, 2'h2, 8'h80, 1'h0},
        {16'h605F, 8'h01, 2'h0, 4'h3, 8'h00, 1'h0, 12'h05F, 1'h1, 2'h1, 8'h01, 1'h0},
        {16'h6060, 8'h01, 2'h0, 4'h3, 8'h02, 1'h1, 12'hF60, 1'h0, 2'h0, 8'h01, 1'h0},
        {16'h6510, 8'h8F, 2'h0, 4'h1, 8'h90, 1'h0, 12'h110, 1'h1, 2'h1, 8'h8F, 1'h0},
        {16'h0007, 8'h45, 2'h0, 4'h0, 8'h00, 1'h0, 12'h000, 1'h0, 2'h0, 8'h45, 1'h0},
        {16'h0007, 8'h3C, 2'h0, 4'h0, 8'h00, 1'h0, 12'h000, 1'h0, 2'h0, 8'h32, 1'h0},
        {16'h0007, 8'h12, 2'h2, 4'h0, 8'h00, 1'h0, 12'h000, 1'h0, 2'h0, 8'h28, 1'h0},
        {16'h0007, 8'hA5, 2'h0, 4'h0, 8'h00, 1'h0, 12'h000, 1'h0, 2'h0, 8'h05, 1'h1},
        {16'h0007, 8'h45, 2'h1, 4'h0, 8'h00, 1'h0, 12'h000, 1'h0, 2'h0, 8'hA5, 1'h1},
        {16'h0007, 8'h95, 2'h2, 4'h0, 8'h00, 1'h0, 12'h000, 1'h0, 2'h0, 8'h0B, 1'h1},
        {16'h0007, 8'hF0, 2'h0, 4'h0, 8'h00, 1'h0, 12'h000, 1'h0, 2'h0, 8'h50, 1'h1}
    };

    logic clk;
    logic rst = 1'h1;
    logic hsel = 1'h0;
    logic hwr = 1'h0;
    logic vld = 1'h1;
    logic two = 1'h0;
    logic [1:0] htr = 2'h0;
    logic [31:0] ha = 32'h0;
    logic [31:0] hwd = 32'h0;
    logic [15:0] ins = 16'h0;
    logic [7:0] mv = 8'h0;
    logic [11:0] ea = 12'h0;
    logic [31:0] hrd;
    logic rdy, resp, rd, skip, nop, cy;
    logic [11:0] da;
    logic [7:0] dd, w;
    logic [3:0] ph;
    int fails = 0;
    int samples_checked = 0;

    // a byte not addressed shows the inverse, so a wrong address cannot pass
    assign dd = (rd && da === ea) ? mv : ~mv;

    csd_core dut (
        .I_CLK(clk), .I_RESET(rst), .I_HSEL(hsel), .I_HADDR(ha), .I_HTRANS(htr),
        .I_HWRITE(hwr), .I_HSIZE(3'h2), .I_HWDATA(hwd), .I_HREADY(rdy), .O_HRDATA(hrd),
        .O_HREADYOUT(rdy), .O_HRESP(resp), .I_INSTR_VALID(vld), .I_INSTR(ins),
        .I_NEXT_TWO_WORD(two), .O_DMEM_ADDR(da), .O_DMEM_RD(rd), .I_DMEM_DATA(dd),
        .O_PHASE(ph), .O_SKIP(skip), .O_NOP_CYCLE(nop), .O_W(w), .O_CARRY(cy)
    );

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // values read right after an edge are those the design sampled there
    task automatic wait_for(input logic [3:0] want);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while ((want == 4'h0 ? rdy !== 1'h1 : ph !== want) && k < 40);
        if (k >= 40) begin
            fails++;
            final_report();
        end
    endtask

    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'h1;
        htr <= 2'h2;
        hwr <= wr_en;
        ha <= {24'h0, a};
        wait_for(4'h0);
        hsel <= 1'h0;
        htr <= 2'h0;
        hwd <= d;
        wait_for(4'h0);
        q = hrd;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        chk(q, e);
    endtask

    // word goes up as decode begins so it stands at the decode edge
    task automatic issue(input logic [15:0] word, input logic [15:0] nxt);
        wait_for(4'h8);
        ins <= word;
        @(posedge clk);
        ins <= nxt;
    endtask

    initial begin
        logic [3:0] p0;
        logic [3:0] n;
        logic [7:0] ns;
        repeat (8) @(posedge clk);
        chk(32'({ph, rdy, resp, skip, nop, w, cy}), 32'h2000);
        rst <= 1'h0;
        @(posedge clk);
        rdc(OFS_WORKING_REGISTER_FILE, 32'h0);
        rdc(OFS_STATUS, 32'h0);
        rdc(OFS_BSR, 32'h0);
        rdc(OFS_CTRL, 32'h1);
        rdc(OFS_SKIPS, 32'h0);
        rdc(8'h18, 32'h0);
        wr(OFS_BSR, 32'hFFFF_FFFF);
        rdc(OFS_BSR, 32'hF);
        wr(OFS_SKIPS, 32'h55);
        rdc(OFS_SKIPS, 32'h0);
        ns = 8'h0;
        for (int r = 0; r < 14; r++) begin
            wr(OFS_WORKING_REGISTER_FILE, 32'(ROWS[r].w));
            wr(OFS_STATUS, 32'(ROWS[r].f));
            wr(OFS_BSR, 32'(ROWS[r].b));
            mv <= ROWS[r].m;
            ea <= ROWS[r].a;
            two <= ROWS[r].t;
            ns = ns + 8'(ROWS[r].s);
            issue(ROWS[r].i, 16'h0);
            @(posedge clk);
            chk(32'({ph, rd}), 32'({4'h2, ROWS[r].i != DAW_WORD}));
            if (ROWS[r].i != DAW_WORD) begin
                chk(32'(da), 32'(ROWS[r].a));
            end
            repeat (2) @(posedge clk);
            chk(32'({ph, skip}), 32'({4'h8, ROWS[r].s}));
            n = 4'h0;
            repeat (12) begin
                @(posedge clk);
                n = n + 4'(nop);
            end
            chk(32'(n), 32'({ROWS[r].n, 2'h0}));
            chk(32'({w, cy}), 32'({ROWS[r].ew, ROWS[r].ec}));
            rdc(OFS_STATUS, 32'({ROWS[r].f[1], ROWS[r].ec}));
        end
        // adjust words offered in both idle cycles must vanish; the third runs once
        wr(OFS_WORKING_REGISTER_FILE, 32'hA5);
        wr(OFS_STATUS, 32'h0);
        mv <= 8'h01;
        ea <= 12'h030;
        two <= 1'h1;
        issue(16'h6030, DAW_WORD);
        repeat (15) @(posedge clk);
        ins <= 16'h0;
        repeat (4) @(posedge clk);
        chk(32'({w, cy}), 32'h00B);
        rdc(OFS_SKIPS, 32'(ns + 8'h1));
        wr(OFS_CTRL, 32'h0);
        @(posedge clk);
        p0 = ph;
        repeat (6) @(posedge clk);
        chk(32'(ph), 32'(p0));
        wr(OFS_CTRL, 32'h1);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        chk(32'({ph, rdy, w}), 32'h200);
        rst <= 1'h0;
        @(posedge clk);
        @(posedge clk);
        chk(32'({ph, rdy}), 32'h5);
        final_report();
    end
endmodule
